// [mgrf_consts.vh]
// Constants for the magnetometer register file: addresses, fields,
// reset values and timing figures. Definitions only.
`ifndef MGRF_CONSTS_VH
`define MGRF_CONSTS_VH
// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define MGRF_A_X_LOW 8'h00
`define MGRF_A_X_HIGH 8'h01
`define MGRF_A_Y_LOW 8'h02
`define MGRF_A_Y_HIGH 8'h03
`define MGRF_A_Z_LOW 8'h04
`define MGRF_A_Z_HIGH 8'h05
`define MGRF_A_FLAGS 8'h06
`define MGRF_A_T_LOW 8'h07
`define MGRF_A_T_HIGH 8'h08
`define MGRF_A_SETUP 8'h09
`define MGRF_A_CTRL2 8'h0a
`define MGRF_A_FLIP 8'h0b
`define MGRF_A_CODE_LO 8'h0e
`define MGRF_A_CODE_HI 8'h11
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MGRF_F_DATA_READY_FLAG 0
`define MGRF_F_OVL 1
`define MGRF_F_SKIP 2
`define MGRF_F_INT_DIS 0
`define MGRF_F_WRAP 6
`define MGRF_F_SRST 7
// ----------------------------------------------------------------------
// Mode codes and reset values
// ----------------------------------------------------------------------
`define MGRF_MODE_STBY 2'h0
`define MGRF_MODE_CONT 2'h1
`define MGRF_MODE_TEST 2'h2
`define MGRF_RST_SETUP 8'h00
`define MGRF_RST_CTRL2 8'h00
`define MGRF_RST_FLIP 8'h00
`define MGRF_RST_DATA 16'h0000
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Rate periods in 10 MHz clock cycles for 10, 50, 100 and 200 Hz
`define MGRF_RATE0_CYC 20'hf4240
`define MGRF_RATE1_CYC 20'h30d40
`define MGRF_RATE2_CYC 20'h186a0
`define MGRF_RATE3_CYC 20'h0c350
`define MGRF_RAW_W 18
`endif

// [mgrf_sat.v]
// Saturates one wide signed axis sample into 16 bits.
// Assumes the raw sample is held stable while it is qualified.
`timescale 1ns/100ps
module mgrf_sat #(
   parameter W = 18
) (
   input wire [W-1:0] raw_in,
   output reg [15:0] sat_out,
   output reg ovf_out
);
   localparam [W-1:0] MAXV = {{(W-15){1'b0}}, 15'h7fff};
   localparam [W-1:0] MINV = {{(W-15){1'b1}}, 15'h0000};
   // --------------------------------------------------------------
   // Clamp to the signed 16-bit range
   // --------------------------------------------------------------
   always @* begin
      if ($signed(raw_in) > $signed(MAXV)) begin
         sat_out = 16'h7fff;
         ovf_out = 1'b1;
      end else if ($signed(raw_in) < $signed(MINV)) begin
         sat_out = 16'h8000;
         ovf_out = 1'b1;
      end else begin
         sat_out = raw_in[15:0];
         ovf_out = 1'b0;
      end
   end
endmodule

// [mgrf_top.v]
// Register file and measurement control of a three-axis magnetometer.
// Assumes a byte-level serial engine in front: it reports the register
// address byte of a write phase, each data byte written, and each byte
// request of a read phase, all synchronous to ref_clk_in.
// Clock enable low freezes every register; reset acts regardless.
// Results load only on a front-end sample strobe in a measuring mode.
// Limitation: a new output rate takes effect at the next timer reload.

`timescale 1ns/100ps
`include "mgrf_consts.vh"
module mgrf_top #(
   parameter [19:0] RATE0_CYC = `MGRF_RATE0_CYC,
   parameter [19:0] RATE1_CYC = `MGRF_RATE1_CYC,
   parameter [19:0] RATE2_CYC = `MGRF_RATE2_CYC,
   parameter [19:0] RATE3_CYC = `MGRF_RATE3_CYC
) (
   input wire ref_clk_in,
   input wire rst_n_in,
   input wire clk_en_in,
   input wire host_addr_valid_in,
   input wire [7:0] host_addr_in,
   input wire host_wdata_valid_in,
   input wire [7:0] host_wdata_in,
   input wire host_rd_req_in,
   output reg [7:0] host_rd_data_out,
   output reg host_rd_valid_out,
   input wire adc_valid_in,
   input wire [`MGRF_RAW_W-1:0] adc_x_in,
   input wire [`MGRF_RAW_W-1:0] adc_y_in,
   input wire [`MGRF_RAW_W-1:0] adc_z_in,
   input wire [15:0] adc_temp_in,
   output reg meas_start_out,
   output reg self_test_out,
   output reg [1:0] field_range_select_out,
   output reg [1:0] oversampling_field_out,
   output reg [7:0] flip_period_value_out,
   output reg int_pin_out
);
   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   reg [15:0] x_axis_result_r;
   reg [15:0] y_axis_result_r;
   reg [15:0] z_axis_result_r;
   reg [15:0] temperature_result_r;
   reg data_ready_flag_r;
   reg overflow_flag_r;
   reg data_skipped_flag_r;
   reg [7:0] setup_r;
   reg interrupt_pin_disable_r;
   reg pointer_wrap_enable_r;
   reg [7:0] flip_period_r;
   reg [31:0] code_r;
   reg [7:0] ptr_r;
   reg start_low_r;
   reg [19:0] timer_r;
   reg [1:0] mode_prev_r;

   wire [15:0] x_sat;
   wire [15:0] y_sat;
   wire [15:0] z_sat;
   wire x_ovf;
   wire y_ovf;
   wire z_ovf;

   wire [1:0] mode = setup_r[1:0];
   wire [1:0] output_rate_field = setup_r[3:2];
   // Reserved code 11 falls through to standby
   wire cont = (mode == `MGRF_MODE_CONT);
   wire test = (mode == `MGRF_MODE_TEST);
   wire measuring = cont | test;

   // Soft reset acts on the write itself, before any register sees it
   wire soft_rst = host_wdata_valid_in && (ptr_r == `MGRF_A_CTRL2) &&
      host_wdata_in[`MGRF_F_SRST];
   // A read of any axis byte counts as the data having been fetched
   wire rd_axis = host_rd_req_in && (ptr_r <= `MGRF_A_Z_HIGH);
   wire load = adc_valid_in && measuring;
   wire wr = host_wdata_valid_in && !soft_rst;

   // --------------------------------------------------------------
   // Saturation, one per axis
   // --------------------------------------------------------------
   // Wide samples let overflow be seen; only the result is clamped
   mgrf_sat #(.W(`MGRF_RAW_W)) u_sat_x (
      .raw_in(adc_x_in),
      .sat_out(x_sat),
      .ovf_out(x_ovf)
   );
   mgrf_sat #(.W(`MGRF_RAW_W)) u_sat_y (
      .raw_in(adc_y_in),
      .sat_out(y_sat),
      .ovf_out(y_ovf)
   );
   mgrf_sat #(.W(`MGRF_RAW_W)) u_sat_z (
      .raw_in(adc_z_in),
      .sat_out(z_sat),
      .ovf_out(z_ovf)
   );

   // --------------------------------------------------------------
   // Rate period select
   // --------------------------------------------------------------
   // Counts are parameters so a bench can shorten them
   reg [19:0] period;
   always @* begin
      case (output_rate_field)
         2'h0: period = RATE0_CYC;
         2'h1: period = RATE1_CYC;
         2'h2: period = RATE2_CYC;
         2'h3: period = RATE3_CYC;
         default: period = RATE0_CYC;
      endcase
   end

   // --------------------------------------------------------------
   // Read data mux
   // --------------------------------------------------------------
   // Unmapped and reserved addresses read as zero
   reg [7:0] rd_mux;
   always @* begin
      case (ptr_r)
         `MGRF_A_X_LOW: rd_mux = x_axis_result_r[7:0];
         `MGRF_A_X_HIGH: rd_mux = x_axis_result_r[15:8];
         `MGRF_A_Y_LOW: rd_mux = y_axis_result_r[7:0];
         `MGRF_A_Y_HIGH: rd_mux = y_axis_result_r[15:8];
         `MGRF_A_Z_LOW: rd_mux = z_axis_result_r[7:0];
         `MGRF_A_Z_HIGH: rd_mux = z_axis_result_r[15:8];
         `MGRF_A_FLAGS: rd_mux = {5'h00, data_skipped_flag_r,
            overflow_flag_r, data_ready_flag_r};
         `MGRF_A_T_LOW: rd_mux = temperature_result_r[7:0];
         `MGRF_A_T_HIGH: rd_mux = temperature_result_r[15:8];
         `MGRF_A_SETUP: rd_mux = setup_r;
         `MGRF_A_CTRL2: rd_mux = {1'b0, pointer_wrap_enable_r, 5'h00,
            interrupt_pin_disable_r};
         `MGRF_A_FLIP: rd_mux = flip_period_r;
         8'h0e: rd_mux = code_r[7:0];
         8'h0f: rd_mux = code_r[15:8];
         8'h10: rd_mux = code_r[23:16];
         8'h11: rd_mux = code_r[31:24];
         default: rd_mux = 8'h00;
      endcase
   end

   // --------------------------------------------------------------
   // Pointer next value
   // --------------------------------------------------------------
   // An address byte wins over a read request in the same cycle
   reg [7:0] ptr_nxt;
   always @* begin
      ptr_nxt = ptr_r;
      if (host_addr_valid_in) begin
         ptr_nxt = host_addr_in;
      end else if (host_rd_req_in) begin
         if (pointer_wrap_enable_r && start_low_r &&
               ptr_r == `MGRF_A_FLAGS) begin
            ptr_nxt = `MGRF_A_X_LOW;
         end else begin
            ptr_nxt = ptr_r + 8'h01;
         end
      end
   end

   // --------------------------------------------------------------
   // Host access and configuration registers
   // --------------------------------------------------------------
   // Soft reset returns every mapped register to default, not the pointer; the reset bit
   // itself is never stored, so it reads back as zero.
   // Read data holds until the next request; reads never touch results.
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         setup_r <= `MGRF_RST_SETUP;
         interrupt_pin_disable_r <= 1'b0;
         pointer_wrap_enable_r <= 1'b0;
         flip_period_r <= `MGRF_RST_FLIP;
         code_r <= 32'h00000000;
         ptr_r <= 8'h00;
         start_low_r <= 1'b0;
         host_rd_data_out <= 8'h00;
         host_rd_valid_out <= 1'b0;
      end else if (clk_en_in) begin
         host_rd_valid_out <= host_rd_req_in;
         if (host_rd_req_in) begin
            host_rd_data_out <= rd_mux;
         end
         ptr_r <= ptr_nxt;
         if (host_addr_valid_in) begin
            start_low_r <= (host_addr_in <= `MGRF_A_FLAGS);
         end
         if (soft_rst) begin
            setup_r <= `MGRF_RST_SETUP;
            interrupt_pin_disable_r <= 1'b0;
            pointer_wrap_enable_r <= 1'b0;
            flip_period_r <= `MGRF_RST_FLIP;
            code_r <= 32'h00000000;
         end else if (wr) begin
            // Write lands at the address of the preceding address byte
            case (ptr_r)
               `MGRF_A_SETUP: setup_r <= host_wdata_in;
               `MGRF_A_CTRL2: begin
                  interrupt_pin_disable_r <=
                     host_wdata_in[`MGRF_F_INT_DIS];
                  pointer_wrap_enable_r <=
                     host_wdata_in[`MGRF_F_WRAP];
               end
               `MGRF_A_FLIP: flip_period_r <= host_wdata_in;
               `MGRF_A_X_LOW, `MGRF_A_X_HIGH, `MGRF_A_Y_LOW,
               `MGRF_A_Y_HIGH, `MGRF_A_Z_LOW, `MGRF_A_Z_HIGH,
               `MGRF_A_FLAGS, `MGRF_A_T_LOW, `MGRF_A_T_HIGH: begin
                  // Results and status are read-only to the host
                  code_r <= code_r;
               end
               8'h0e: code_r[7:0] <= host_wdata_in;
               8'h0f: code_r[15:8] <= host_wdata_in;
               8'h10: code_r[23:16] <= host_wdata_in;
               8'h11: code_r[31:24] <= host_wdata_in;
               default: code_r <= code_r;
            endcase
         end
      end
   end

   // --------------------------------------------------------------
   // Measurement timer
   // --------------------------------------------------------------
   // The timer restarts on every mode change so the first conversion
   // of a new mode is requested at once.
   // Clock enable low holds everything, a start pulse included.
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         timer_r <= 20'h00000;
         mode_prev_r <= `MGRF_MODE_STBY;
         meas_start_out <= 1'b0;
      end else if (clk_en_in) begin
         mode_prev_r <= mode;
         meas_start_out <= 1'b0;
         if (!measuring || soft_rst) begin
            timer_r <= 20'h00000;
         end else if (mode != mode_prev_r) begin
            timer_r <= 20'h00000;
         end else if (timer_r == 20'h00000) begin
            timer_r <= period - 20'h00001;
            meas_start_out <= 1'b1;
         end else begin
            timer_r <= timer_r - 20'h00001;
         end
      end
   end

   // --------------------------------------------------------------
   // Results and status flags
   // --------------------------------------------------------------
   // A load in the same cycle as an axis read wins over the ready clear; skip still clears.
   // Overflow is rewritten by every load, so one clean set clears it.
   // Skip is judged only in continuous mode, never in self-test.
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         x_axis_result_r <= `MGRF_RST_DATA;
         y_axis_result_r <= `MGRF_RST_DATA;
         z_axis_result_r <= `MGRF_RST_DATA;
         temperature_result_r <= `MGRF_RST_DATA;
         data_ready_flag_r <= 1'b0;
         overflow_flag_r <= 1'b0;
         data_skipped_flag_r <= 1'b0;
      end else if (clk_en_in) begin
         if (soft_rst) begin
            x_axis_result_r <= `MGRF_RST_DATA;
            y_axis_result_r <= `MGRF_RST_DATA;
            z_axis_result_r <= `MGRF_RST_DATA;
            temperature_result_r <= `MGRF_RST_DATA;
            data_ready_flag_r <= 1'b0;
            overflow_flag_r <= 1'b0;
            data_skipped_flag_r <= 1'b0;
         end else begin
            if (load) begin
               x_axis_result_r <= x_sat;
               y_axis_result_r <= y_sat;
               z_axis_result_r <= z_sat;
               temperature_result_r <= adc_temp_in;
               overflow_flag_r <= x_ovf | y_ovf | z_ovf;
            end
            if (load) begin
               data_ready_flag_r <= 1'b1;
            end else if (rd_axis) begin
               data_ready_flag_r <= 1'b0;
            end
            if (load && cont && data_ready_flag_r && !rd_axis) begin
               data_skipped_flag_r <= 1'b1;
            end else if (rd_axis) begin
               data_skipped_flag_r <= 1'b0;
            end
         end
      end
   end

   // --------------------------------------------------------------
   // Front-end settings and interrupt pin
   // --------------------------------------------------------------
   // Settings are registered copies, so the front end sees a change
   // one cycle after the write.
   // The pin drops with the soft-reset write itself, a cycle early.
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         self_test_out <= 1'b0;
         field_range_select_out <= 2'h0;
         oversampling_field_out <= 2'h0;
         flip_period_value_out <= `MGRF_RST_FLIP;
         int_pin_out <= 1'b0;
      end else if (clk_en_in) begin
         self_test_out <= test;
         field_range_select_out <= setup_r[5:4];
         oversampling_field_out <= setup_r[7:6];
         flip_period_value_out <= flip_period_r;
         int_pin_out <= data_ready_flag_r && !interrupt_pin_disable_r &&
            !soft_rst;
      end
   end
endmodule

// [mgrf_host_bfm.sv]
// Host-side byte master for the magnetometer register file.
// Assumes the design samples requests on the rising clock edge.
`timescale 1ns/100ps
module mgrf_host_bfm (
   input wire clk_in,
   input wire [7:0] rdd_in,
   input wire rdv_in,
   output reg av_out,
   output reg [7:0] a_out,
   output reg wv_out,
   output reg [7:0] w_out,
   output reg rq_out
);
   reg [7:0] rbuf [0:15];
   initial begin
      av_out = 1'b0;
      a_out = 8'h00;
      wv_out = 1'b0;
      w_out = 8'h00;
      rq_out = 1'b0;
   end
   // ----
   // Byte cycles
   // ----
   // Idle bytes show the inverse of the last one, never a held copy
   task put_addr(input [7:0] a);
      begin
         @(negedge clk_in);
         av_out = 1'b1;
         a_out = a;
         @(negedge clk_in);
         av_out = 1'b0;
         a_out = ~a;
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         put_addr(a);
         wv_out = 1'b1;
         w_out = d;
         @(negedge clk_in);
         wv_out = 1'b0;
         w_out = ~d;
      end
   endtask
   // A missing answer leaves an unknown byte for the bench to catch
   task rd(input [7:0] a, input integer n);
      integer i;
      begin
         put_addr(a);
         // Back-to-back byte requests; each answer stands one cycle
         for (i = 0; i < n; i = i + 1) begin
            rq_out = 1'b1;
            @(negedge clk_in);
            rbuf[i] = rdv_in ? rdd_in : 8'hxx;
         end
         rq_out = 1'b0;
      end
   endtask
endmodule

// [mgrf_top_chk.sv]
// Port checker for the magnetometer register file.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module mgrf_top_chk (
   input wire ref_clk_in,
   input wire rst_n_in,
   input wire clk_en_in,
   input wire host_wdata_valid_in,
   input wire host_rd_req_in,
   input wire [7:0] host_rd_data_out,
   input wire host_rd_valid_out,
   input wire adc_valid_in,
   input wire meas_start_out,
   input wire self_test_out,
   input wire [1:0] field_range_select_out,
   input wire [1:0] oversampling_field_out,
   input wire [7:0] flip_period_value_out,
   input wire int_pin_out
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_start_soon;
      ##[0:3] meas_start_out;
   endsequence
   a_rd_answer: assert property (
      host_rd_req_in && clk_en_in |=> host_rd_valid_out)
      else $error("read answer missing");
   a_rd_no_spurious: assert property (
      $rose(host_rd_valid_out) |-> $past(host_rd_req_in))
      else $error("read answer without request");
   a_rd_data_hold: assert property (
      !$past(host_rd_req_in) && !$past(host_wdata_valid_in)
      |-> $stable(host_rd_data_out)) else $error("read data moved");
   a_int_cause: assert property (
      $rose(int_pin_out) |-> $past(adc_valid_in, 2)
      || $past(host_wdata_valid_in, 2) || $past(host_wdata_valid_in, 3))
      else $error("interrupt without new data");
   // Config copies lag a write by up to three edges
   a_rng_by_write: assert property (
      !$stable(field_range_select_out) |-> $past(host_wdata_valid_in)
      || $past(host_wdata_valid_in, 2) || $past(host_wdata_valid_in, 3))
      else $error("range changed without write");
   a_osr_by_write: assert property (
      !$stable(oversampling_field_out) |-> $past(host_wdata_valid_in)
      || $past(host_wdata_valid_in, 2) || $past(host_wdata_valid_in, 3))
      else $error("oversampling changed without write");
   a_flip_by_write: assert property (
      !$stable(flip_period_value_out) |-> $past(host_wdata_valid_in)
      || $past(host_wdata_valid_in, 2) || $past(host_wdata_valid_in, 3))
      else $error("flip period changed without write");
   a_start_pulse: assert property (
      meas_start_out && clk_en_in |=> !meas_start_out)
      else $error("start longer than one cycle");
   a_test_start: assert property (
      $rose(self_test_out) |-> s_start_soon)
      else $error("self test started no conversion");
   a_freeze_hold: assert property (
      !clk_en_in |=> $stable(meas_start_out) && $stable(int_pin_out))
      else $error("state moved while frozen");
endmodule
bind mgrf_top mgrf_top_chk u_chk (.ref_clk_in(ref_clk_in),
   .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
   .host_wdata_valid_in(host_wdata_valid_in),
   .host_rd_req_in(host_rd_req_in), .host_rd_data_out(host_rd_data_out),
   .host_rd_valid_out(host_rd_valid_out), .adc_valid_in(adc_valid_in),
   .meas_start_out(meas_start_out), .self_test_out(self_test_out),
   .field_range_select_out(field_range_select_out),
   .oversampling_field_out(oversampling_field_out),
   .flip_period_value_out(flip_period_value_out),
   .int_pin_out(int_pin_out));

// [tb_top.sv]
// Self-checking bench for the magnetometer register file.
// Assumes 10 MHz; rate counts shortened to 40/20/10/5 cycles.
`timescale 1ns/100ps
module tb_top;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg en = 1'b1;
   reg av = 1'b0;
   reg [17:0] ax = 18'h00000, ay = 18'h00000, az = 18'h00000;
   reg [15:0] at = 16'h8123;
   wire [7:0] ha, hw, rdd, flip;
   wire hav, hwv, hrq, rdv, ms, st, ip;
   wire [1:0] field_range_select, oversampling_field;
   integer bad_count = 0, n_checks = 0, i, r, c;
   // Address, write value, expected read-back
   reg [239:0] rows = {24'h09d4d4, 24'h0bffff, 24'h0a7f41, 24'h06ff00,
      24'h005a00, 24'h08a500, 24'h0c3300, 24'h0ea5a5, 24'h113c3c,
      24'h0a0000};
   reg [71:0] burst = 72'hff7f00800700_02ff7f;
   always #50 clk = ~clk;
   mgrf_host_bfm h (.clk_in(clk), .rdd_in(rdd), .rdv_in(rdv),
      .av_out(hav), .a_out(ha), .wv_out(hwv), .w_out(hw), .rq_out(hrq));
   mgrf_top #(.RATE0_CYC(20'h28), .RATE1_CYC(20'h14),
      .RATE2_CYC(20'ha), .RATE3_CYC(20'h5)) dut (.ref_clk_in(clk),
      .rst_n_in(rst_n), .clk_en_in(en), .host_addr_valid_in(hav),
      .host_addr_in(ha), .host_wdata_valid_in(hwv), .host_wdata_in(hw),
      .host_rd_req_in(hrq), .host_rd_data_out(rdd),
      .host_rd_valid_out(rdv), .adc_valid_in(av), .adc_x_in(ax),
      .adc_y_in(ay), .adc_z_in(az), .adc_temp_in(at),
      .meas_start_out(ms), .self_test_out(st),
      .field_range_select_out(field_range_select), .oversampling_field_out(oversampling_field),
      .flip_period_value_out(flip), .int_pin_out(ip));
   // ----
   // Tasks
   // ----
   task chk(input [95:0] nm, input [15:0] e, input [15:0] s);
      begin
         n_checks = n_checks + 1;
         if (s !== e) begin
            bad_count = bad_count + 1;
            $display("ERROR %0s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   // Sample lines go to their inverse once the strobe drops
   task meas(input [17:0] x, input [17:0] y, input [17:0] z);
      begin
         @(negedge clk);
         av = 1'b1;
         ax = x;
         ay = y;
         az = z;
         @(negedge clk);
         av = 1'b0;
         ax = ~x;
         ay = ~y;
         az = ~z;
         repeat (3) @(negedge clk);
      end
   endtask
   // Bounded so a dead timer cannot hang the run
   task nxt(output integer n);
      begin
         n = 0;
         do begin
            @(negedge clk);
            n = n + 1;
         end while (ms !== 1'b1 && n < 100);
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   initial begin
      #2000000;
      bad_count = bad_count + 1;
      conclude;
   end
   // ----
   // Tests
   // ----
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      h.rd(8'h00, 12);
      for (i = 0; i < 12; i = i + 1)
         chk("reset reg", 16'h0000, h.rbuf[i]);
      chk("reset outs", 16'h0000, {st, field_range_select, oversampling_field, flip, ip, ms});
      for (i = 0; i < 10; i = i + 1) begin
         h.wr(rows[216-24*i+16 +: 8], rows[216-24*i+8 +: 8]);
         h.rd(rows[216-24*i+16 +: 8], 1);
         chk("readback", rows[216-24*i +: 8], h.rbuf[0]);
      end
      chk("range", 16'h0001, field_range_select);
      chk("oversample", 16'h0003, oversampling_field);
      chk("flip", 16'h00ff, flip);
      $display("test registers done");
      for (r = 0; r < 4; r = r + 1) begin
         h.wr(8'h09, {4'h0, r[1:0], 2'h1});
         nxt(c);
         nxt(c);
         chk("period", 40 >> r, c);
      end
      $display("test rates done");
      meas(18'h00064, 18'h3ff9c, 18'h3fffb);
      h.rd(8'h06, 1);
      chk("flags", 16'h0001, h.rbuf[0]);
      chk("int pin", 16'h0001, ip);
      meas(18'h09c40, 18'h363c0, 18'h00007);
      h.rd(8'h06, 1);
      chk("flags", 16'h0007, h.rbuf[0]);
      h.wr(8'h0a, 8'h40);
      h.rd(8'h00, 9);
      for (i = 0; i < 9; i = i + 1)
         chk("burst", burst[64-8*i +: 8], h.rbuf[i]);
      h.rd(8'h07, 2);
      chk("temp", 16'h8123, {h.rbuf[1], h.rbuf[0]});
      meas(18'h00001, 18'h00002, 18'h00003);
      h.rd(8'h06, 1);
      chk("flags", 16'h0001, h.rbuf[0]);
      h.wr(8'h0a, 8'h01);
      repeat (3) @(negedge clk);
      chk("int pin", 16'h0000, ip);
      $display("test measure done");
      h.wr(8'h09, 8'h03);
      c = 0;
      repeat (30) begin
         @(negedge clk);
         c = c + ms;
      end
      chk("starts", 16'h0000, c);
      meas(18'h00100, 18'h00100, 18'h00100);
      h.rd(8'h00, 1);
      chk("x low", 16'h0001, h.rbuf[0]);
      h.wr(8'h09, 8'h02);
      meas(18'h00011, 18'h00022, 18'h00033);
      meas(18'h00011, 18'h00022, 18'h00033);
      chk("self test", 16'h0001, st);
      h.rd(8'h06, 1);
      chk("flags", 16'h0001, h.rbuf[0]);
      h.rd(8'h00, 2);
      chk("x axis", 16'h0011, {h.rbuf[1], h.rbuf[0]});
      en = 1'b0;
      repeat (8) @(negedge clk);
      en = 1'b1;
      $display("test modes done");
      h.wr(8'h0a, 8'h80);
      h.rd(8'h09, 3);
      for (i = 0; i < 3; i = i + 1)
         chk("soft reset", 16'h0000, h.rbuf[i]);
      h.rd(8'h0e, 1);
      chk("code byte", 16'h0000, h.rbuf[0]);
      chk("self test", 16'h0000, st);
      $display("test soft reset done");
      conclude;
   end
endmodule
